// *** hw/bbad_defs.vh ***
/*
 * Address map constants for the bit-band alias and address decode block.
 * Assumes byte addresses on a 32-bit system bus.
 */
`ifndef BBAD_DEFS_VH
`define BBAD_DEFS_VH

// Memory and bit-band regions
`define BBAD_SRAM_BASE 32'h2000_0000
`define BBAD_SRAM_ALIAS_BASE 32'h2200_0000
`define BBAD_PERI_BASE 32'h4000_0000
`define BBAD_PERI_ALIAS_BASE 32'h4200_0000
`define BBAD_BAND_SPAN 32'h0010_0000
`define BBAD_ALIAS_SPAN 32'h0200_0000
`define BBAD_SRAM_MAX_BYTES 32'h0000_8000
// Peripheral window size
`define BBAD_WIN_SIZE 32'h0000_0400
// High-speed bus windows
`define BBAD_FIRST_DMA_CONTROLLER_BASE 32'h4002_0000
`define BBAD_SECOND_DMA_CONTROLLER_BASE 32'h4002_0400
`define BBAD_RCC_BASE 32'h4002_1000
`define BBAD_FLASHIF_BASE 32'h4002_2000
`define BBAD_CRC_BASE 32'h4002_3000
// Second peripheral bus port windows
`define BBAD_PORT_FIRST_BASE 32'h4001_0800
`define BBAD_PORT_COUNT 3'h7
// First peripheral bus serial windows
`define BBAD_SSP3_BASE 32'h4000_3C00
`define BBAD_ASP4_BASE 32'h4000_4C00
`define BBAD_ASP5_BASE 32'h4000_5000
// Select vector bit positions
`define BBAD_SEL_FIRST_DMA_CONTROLLER 0
`define BBAD_SEL_SECOND_DMA_CONTROLLER 1
`define BBAD_SEL_RCC 2
`define BBAD_SEL_FLASHIF 3
`define BBAD_SEL_CRC 4
`define BBAD_SEL_PORT0 5
`define BBAD_SEL_SSP3 12
`define BBAD_SEL_ASP4 13
`define BBAD_SEL_ASP5 14
`define BBAD_SEL_WIDTH 15
// Access size codes
`define BBAD_SIZE_BYTE 2'h0
`define BBAD_SIZE_HALF 2'h1
`define BBAD_SIZE_WORD 2'h2

`endif

// *** hw/bbad_decode.v ***
/*
 * Combinational decode of a peripheral byte address into one-hot
 * window selects. Assumes the address is already a physical
 * (non-alias) address.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bbad_defs.vh"

module bbad_decode (
   // Address in
   input wire [31:0] addr,
   // Selects out
   output reg [`BBAD_SEL_WIDTH-1:0] sel
);

   // Window base of the address
   wire [31:0] win_base = {addr[31:10], 10'h000};
   // Port window byte offset relative to the first port
   wire [31:0] port_off = win_base - `BBAD_PORT_FIRST_BASE;
   integer i;

   // One-hot select of every decoded window, reserved gaps give zero
   always @* begin
      sel = {`BBAD_SEL_WIDTH{1'b0}};
      sel[`BBAD_SEL_FIRST_DMA_CONTROLLER] = (win_base == `BBAD_FIRST_DMA_CONTROLLER_BASE);
      sel[`BBAD_SEL_SECOND_DMA_CONTROLLER] = (win_base == `BBAD_SECOND_DMA_CONTROLLER_BASE);
      sel[`BBAD_SEL_RCC] = (win_base == `BBAD_RCC_BASE);
      sel[`BBAD_SEL_FLASHIF] = (win_base == `BBAD_FLASHIF_BASE);
      sel[`BBAD_SEL_CRC] = (win_base == `BBAD_CRC_BASE);
      // Seven consecutive port windows
      for (i = 0; i < `BBAD_PORT_COUNT; i = i + 1) begin
         sel[`BBAD_SEL_PORT0 + i] = (port_off == i * 32'h0000_0400);
      end
      sel[`BBAD_SEL_SSP3] = (win_base == `BBAD_SSP3_BASE);
      sel[`BBAD_SEL_ASP4] = (win_base == `BBAD_ASP4_BASE);
      sel[`BBAD_SEL_ASP5] = (win_base == `BBAD_ASP5_BASE);
   end

endmodule
`default_nettype wire

// *** hw/bbad_sram.v ***
/*
 * Flip-flop static RAM with per-byte write enables.
 * Assumes one access per cycle; read data is registered.
 */
`timescale 1ns/1ps
`default_nettype none

module bbad_sram #(
   parameter AW = 13
) (
   // Clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // Access port
   input wire [AW-1:0] widx,
   input wire [3:0] be,
   input wire we,
   input wire [31:0] wdata,
   output reg [31:0] rdata_r
);

   // Word assembled from the byte lanes
   wire [31:0] rd_w;
   genvar g;

   // Byte lanes, little-endian: lane 0 is bits 7:0
   generate
      for (g = 0; g < 4; g = g + 1) begin : lane
         // Storage of one byte lane, one writer per lane
         reg [7:0] mem [0:(1<<AW)-1];
         // Lane write
         always @(posedge ref_clk) begin
            if (we && be[g]) begin
               mem[widx] <= wdata[8*g+7:8*g];
            end
         end
         // Lane read
         assign rd_w[8*g+7:8*g] = mem[widx];
      end
   endgenerate

   // Registered read of the whole word
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rd_w;
      end
   end

endmodule
`default_nettype wire

// *** hw/bbad_top.v ***
/*
 * Bit-band alias translation and address decode for the system bus.
 * Assumes a master that holds one request (req high) until ack,
 * and peripherals that answer a one-cycle strobe with a ready pulse.
 */
// Overview of operation
// - SRAM takes byte, half, word accesses per lane
// - SRAM decoded from fixed base, up to 32 KB
// - Two bit-band regions, each with alias region
// - Alias address = base + offset*32 + bit*4
// - Bit position selects bit zero to seven
// - Alias write is atomic single-bit read-modify-write
// - Alias read returns 0x01 or 0x00
// - SRAM and peripherals both lie in bit-band
// - Decode two DMA controller 1 KB windows
// - Decode clock block, flash interface, CRC windows
// - Decode seven consecutive I/O port windows
// - Decode serial port three, four, five windows
// - Bytes stored little-endian
`timescale 1ns/1ps
`default_nettype none
`include "bbad_defs.vh"

module bbad_top #(
   parameter SRAM_AW = 13
) (
   // Clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // Master request
   input wire req,
   input wire we,
   input wire [1:0] size,
   input wire [31:0] addr,
   input wire [31:0] wdata,
   // Master answer
   output reg ack_r,
   output reg err_r,
   output reg [31:0] rdata_r,
   // Peripheral side
   output reg per_stb_r,
   output reg per_we_r,
   output reg [3:0] per_be_r,
   output reg [31:0] per_addr_r,
   output reg [31:0] per_wdata_r,
   output reg [`BBAD_SEL_WIDTH-1:0] per_sel_r,
   input wire per_ready,
   input wire [31:0] per_rdata
);

   // State codes
   // One access at a time: nothing else reaches the target
   // word between the read and the write of an alias update
   localparam ST_IDLE = 3'h0;
   localparam ST_SRD = 3'h1;
   localparam ST_SMOD = 3'h2;
   localparam ST_PWAIT = 3'h3;
   localparam ST_PMOD = 3'h4;
   localparam ST_DONE = 3'h5;

   // Sequencer
   reg [2:0] st_r; // Sequencer state
   reg [2:0] st_nxt; // Next state
   // Request latched at the take edge
   reg alias_r; // Current access is alias
   reg [2:0] bit_r; // Target bit in byte
   reg [1:0] lane_r; // Target byte lane
   reg newbit_r; // Bit value for alias write
   reg awe_r; // Alias access is a write
   // Physical target of the access
   reg [31:0] paddr_r; // Physical byte address
   reg [1:0] size_r; // Latched access size

   // Alias region hits
   wire in_sram_alias = (addr - `BBAD_SRAM_ALIAS_BASE) < `BBAD_ALIAS_SPAN;
   wire in_peri_alias = (addr - `BBAD_PERI_ALIAS_BASE) < `BBAD_ALIAS_SPAN;
   wire is_alias = in_sram_alias || in_peri_alias;
   // Alias base of the region that was hit
   wire [31:0] alias_base = in_sram_alias ? `BBAD_SRAM_ALIAS_BASE : `BBAD_PERI_ALIAS_BASE;
   // Byte offset and bit number inverted from the alias formula
   wire [31:0] a_off = addr - alias_base;
   wire [31:0] band_byte = {5'h00, a_off[31:5]};
   wire [2:0] a_bit = a_off[4:2];
   wire [31:0] band_base = in_sram_alias ? `BBAD_SRAM_BASE : `BBAD_PERI_BASE;
   wire [31:0] phys = is_alias ? band_base + band_byte : addr;
   // SRAM window hit, capacity from the index width
   wire [31:0] sram_off = phys - `BBAD_SRAM_BASE;
   // Capacity in bytes: four per index
   wire [31:0] sram_cap = 32'h0000_0004 << SRAM_AW;
   wire in_sram = sram_off < sram_cap;
   // Addresses past the capacity fall through to the refusal path
   wire [`BBAD_SEL_WIDTH-1:0] sel;
   // Byte enables for a direct access, from size and low address
   reg [3:0] be_d;
   // SRAM port controls
   reg s_we;
   reg [3:0] s_be;
   reg [31:0] s_wd;
   wire [31:0] s_rd;
   // Offset of the latched target inside the SRAM window
   wire [31:0] paddr_off = paddr_r - `BBAD_SRAM_BASE;
   // Index from the live request in idle, from the latch after
   wire [SRAM_AW-1:0] s_idx = (st_r == ST_IDLE) ? sram_off[SRAM_AW+1:2] :
                              paddr_off[SRAM_AW+1:2];
   // Merged byte for alias modify
   wire [31:0] src_word = (st_r == ST_SMOD) ? s_rd : per_rdata;
   wire [7:0] old_byte = src_word[8*lane_r +: 8];
   reg [7:0] mod_byte;

   // Peripheral window decode
   // Fed with the physical address so alias hits decode too
   bbad_decode u_dec (
      .addr(phys),
      .sel(sel)
   );

   // Flip-flop SRAM
   // Index width sets the capacity
   bbad_sram #(
      .AW(SRAM_AW)
   ) u_sram (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .widx(s_idx),
      .be(s_be),
      .we(s_we),
      .wdata(s_wd),
      .rdata_r(s_rd)
   );

   // Byte enables for byte, half and word
   always @* begin
      // Halves take their lane pair from address bit one
      case (size)
         `BBAD_SIZE_BYTE: be_d = 4'h1 << addr[1:0];
         `BBAD_SIZE_HALF: be_d = addr[1] ? 4'hC : 4'h3;
         default: be_d = 4'hF;
      endcase
   end

   // New byte with only the target bit changed
   always @* begin
      // One bit of eight changes, the rest are kept
      mod_byte = old_byte;
      mod_byte[bit_r] = newbit_r;
   end

   // SRAM port drive: direct write in idle, merged write on modify
   always @* begin
      s_we = 1'b0;
      s_be = 4'h0;
      s_wd = wdata;
      // Direct writes land at the take edge, no wait state
      if (st_r == ST_IDLE && req && !ack_r && !is_alias && in_sram && we) begin
         s_we = 1'b1;
         s_be = be_d;
      end else if (st_r == ST_SMOD && awe_r) begin
         // Alias write: only the target lane is enabled
         s_we = 1'b1;
         s_be = 4'h1 << lane_r;
         s_wd = {4{mod_byte}};
      end
   end

   // Next state
   always @* begin
      st_nxt = st_r;
      case (st_r)
         // Take a request once the previous ack has gone
         ST_IDLE: begin
            if (req && !ack_r) begin
               if (in_sram) begin
                  st_nxt = (we && !is_alias) ? ST_DONE : ST_SRD;
               end else if (|sel) begin
                  st_nxt = ST_PWAIT;
               end else begin
                  st_nxt = ST_DONE;
               end
            end
         end
         // Read word stands one cycle after the take
         ST_SRD: st_nxt = alias_r ? ST_SMOD : ST_DONE;
         // One merge cycle, then answer
         ST_SMOD: st_nxt = ST_DONE;
         // First peripheral answer
         ST_PWAIT: begin
            if (per_ready) begin
               st_nxt = (alias_r && awe_r) ? ST_PMOD : ST_DONE;
            end
         end
         // Write-back answer
         ST_PMOD: begin
            if (per_ready) begin
               st_nxt = ST_DONE;
            end
         end
         // Answer cycle
         ST_DONE: st_nxt = ST_IDLE;
         // Unused codes
         default: st_nxt = ST_IDLE;
      endcase
   end

   // Sequencer and outputs
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         // Idle with every output low
         st_r <= ST_IDLE;
         alias_r <= 1'b0;
         bit_r <= 3'h0;
         lane_r <= 2'h0;
         newbit_r <= 1'b0;
         awe_r <= 1'b0;
         paddr_r <= 32'h0000_0000;
         size_r <= 2'h0;
         ack_r <= 1'b0;
         err_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         per_stb_r <= 1'b0;
         per_we_r <= 1'b0;
         per_be_r <= 4'h0;
         per_addr_r <= 32'h0000_0000;
         per_wdata_r <= 32'h0000_0000;
         per_sel_r <= {`BBAD_SEL_WIDTH{1'b0}};
      end else begin
         st_r <= st_nxt;
         // Pulses last one cycle unless set below
         ack_r <= 1'b0;
         err_r <= 1'b0;
         per_stb_r <= 1'b0;
         case (st_r)
            // Take: latch the target once the last ack has gone
            ST_IDLE: begin
               if (req && !ack_r) begin
                  // Latch the translated access
                  alias_r <= is_alias;
                  bit_r <= a_bit;
                  lane_r <= phys[1:0];
                  newbit_r <= wdata[0];
                  awe_r <= we;
                  paddr_r <= phys;
                  size_r <= size;
                  if (!in_sram && |sel) begin
                     // Alias accesses read first, writes come after
                     per_stb_r <= 1'b1;
                     per_we_r <= we && !is_alias;
                     per_be_r <= is_alias ? 4'h1 << phys[1:0] : be_d;
                     per_addr_r <= {phys[31:2], 2'h0};
                     per_wdata_r <= wdata;
                     per_sel_r <= sel;
                  end else if (!in_sram) begin
                     err_r <= 1'b1; // Reserved or unmapped
                  end
               end
            end
            // Direct read data one cycle after the take
            ST_SRD: begin
               if (!alias_r) begin
                  rdata_r <= s_rd;
               end
            end
            // Merge cycle for SRAM alias accesses
            ST_SMOD: begin
               // Alias read answer 0x01 or 0x00
               rdata_r <= {31'h000_0000, old_byte[bit_r]};
            end
            // Wait for the peripheral answer
            ST_PWAIT: begin
               if (per_ready) begin
                  if (alias_r) begin
                     rdata_r <= {31'h000_0000, old_byte[bit_r]};
                  end else begin
                     rdata_r <= per_rdata;
                  end
                  if (alias_r && awe_r) begin
                     // Write back only the merged byte
                     per_stb_r <= 1'b1;
                     per_we_r <= 1'b1;
                     per_wdata_r <= {4{mod_byte}};
                  end
               end
            end
            // Wait for the write-back answer
            ST_PMOD: begin
               per_stb_r <= 1'b0;
            end
            // Answer the master and free the window
            ST_DONE: begin
               ack_r <= 1'b1;
               per_sel_r <= {`BBAD_SEL_WIDTH{1'b0}};
               if (!alias_r && !awe_r && size_r == `BBAD_SIZE_WORD) begin
                  rdata_r <= rdata_r;
               end
            end
            // Unused codes fall back to idle
            default: begin
               ack_r <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// *** dv/bbad_monitor.sv ***
/*
 Concurrent checks on the ports of the alias and decode top.
 Assumes one clock and an active high asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bbad_monitor (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Master side
   input wire logic req,
   input wire logic we,
   input wire logic [31:0] addr,
   input wire logic ack_r,
   input wire logic err_r,
   input wire logic [31:0] rdata_r,
   // Peripheral side
   input wire logic per_stb_r,
   input wire logic [31:0] per_addr_r,
   input wire logic [14:0] per_sel_r
);
   // One clock domain for every check
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   ack_pulse_a: assert property (ack_r |=> !ack_r)
      else $error("ack longer than one cycle");
   sram_write_a: assert property (
      $rose(req) && we && addr[31:15] == 17'h4000 |-> ##[2:3] ack_r)
      else $error("sram write not acked in time");
   alias_read_a: assert property (
      $rose(req) && !we && addr[31:25] == 7'h11 |-> ##[4:5] ack_r && rdata_r[31:1] == 31'h0)
      else $error("alias read not 0 or 1");
   stb_onehot_a: assert property (per_stb_r |-> $onehot(per_sel_r))
      else $error("select not one-hot");
   dma_first_a: assert property (
      per_stb_r && per_sel_r[0] |-> per_addr_r[31:10] == 22'h10_0080)
      else $error("first dma window wrong");
   dma_second_a: assert property (
      per_stb_r && per_sel_r[1] |-> per_addr_r[31:10] == 22'h10_0081)
      else $error("second dma window wrong");
   crc_window_a: assert property (
      per_stb_r && per_sel_r[4] |-> per_addr_r[31:10] == 22'h10_008C)
      else $error("crc window wrong");
   reserved_err_a: assert property (
      $rose(req) && addr[31:10] == 22'h10_0082 |-> ##[1:2] err_r)
      else $error("reserved gap not refused");
   err_ack_a: assert property (err_r |=> ack_r)
      else $error("err without ack");
   port_last_a: assert property (
      per_stb_r && per_sel_r[11] |-> per_addr_r[31:10] == 22'h10_0048)
      else $error("seventh port window wrong");
   async_five_a: assert property (
      per_stb_r && per_sel_r[14] |-> per_addr_r[31:10] == 22'h10_0014)
      else $error("fifth serial window wrong");
endmodule
`default_nettype wire

// *** dv/bbad_per_model.sv ***
/*
 Behavioural peripheral responder: one word store per window select.
 Assumes a one-cycle strobe and answers with a one-cycle ready pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module bbad_per_model (
   // Clock
   input wire logic ref_clk,
   // Request from the bridge
   input wire logic per_stb_r,
   input wire logic per_we_r,
   input wire logic [3:0] per_be_r,
   input wire logic [31:0] per_wdata_r,
   input wire logic [14:0] per_sel_r,
   // Answer
   output logic per_ready,
   output logic [31:0] per_rdata
);
   logic [31:0] mem [0:14]; // One word per window
   logic slow_r; // Alternates prompt and slow answers
   int k;
   int slot;
   // Serve one strobe at a time; data line toggles while idle
   initial begin
      per_ready = 1'b0;
      per_rdata = 32'h0000_0000;
      slow_r = 1'b0;
      for (k = 0; k < 15; k++) mem[k] = 32'h0000_0000;
      forever begin
         @(posedge ref_clk);
         #1;
         per_ready = 1'b0;
         per_rdata = ~per_rdata;
         if (per_stb_r === 1'b1) begin
            slot = 0;
            for (k = 0; k < 15; k++) if (per_sel_r[k]) slot = k;
            // Lane merge keeps untouched bytes
            if (per_we_r) for (k = 0; k < 4; k++)
               if (per_be_r[k]) mem[slot][8*k+:8] = per_wdata_r[8*k+:8];
            repeat (slow_r ? 4 : 1) @(posedge ref_clk);
            #1;
            slow_r = ~slow_r;
            per_ready = 1'b1;
            per_rdata = mem[slot];
         end
      end
   end
endmodule
`default_nettype wire

// *** dv/test_bbad_top.sv ***
/*
 Directed bench for the alias and decode top with a small SRAM.
 Assumes the peripheral model answers every strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module test_bbad_top;
   logic ref_clk, sys_rst, req, we, per_ready;
   logic [1:0] size;
   logic [31:0] addr, wdata, per_rdata, rdata_r, per_addr_r, per_wdata_r, q;
   logic ack_r, err_r, per_stb_r, per_we_r, e;
   logic [3:0] per_be_r;
   logic [14:0] per_sel_r;
   int bad_count = 0;
   int checks = 0;
   int i;
   bbad_top #(.SRAM_AW(6)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .we(we),
      .size(size), .addr(addr), .wdata(wdata), .ack_r(ack_r), .err_r(err_r), .rdata_r(rdata_r),
      .per_stb_r(per_stb_r), .per_we_r(per_we_r), .per_be_r(per_be_r), .per_addr_r(per_addr_r),
      .per_wdata_r(per_wdata_r), .per_sel_r(per_sel_r), .per_ready(per_ready),
      .per_rdata(per_rdata));
   bbad_per_model pm (.ref_clk(ref_clk), .per_stb_r(per_stb_r), .per_we_r(per_we_r),
      .per_be_r(per_be_r), .per_wdata_r(per_wdata_r), .per_sel_r(per_sel_r),
      .per_ready(per_ready), .per_rdata(per_rdata));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One master access, held until ack is sampled
   task automatic bus(input logic w, input logic [1:0] s, input logic [31:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      e = 1'b0;
      @(posedge ref_clk);
      #1;
      {req, we, size, addr, wdata} = {1'b1, w, s, a, d};
      do begin
         @(negedge ref_clk);
         if (err_r === 1'b1) e = 1'b1;
         n++;
      end while (ack_r !== 1'b1 && n < 60);
      q = rdata_r;
      if (n >= 60) chk(32'h0000_0001, 32'h0000_0000);
      @(posedge ref_clk);
      #1;
      req = 1'b0;
   endtask
   // Lanes, little-endian order, top word
   task automatic t_sram;
      bus(1, 2'h2, 32'h2000_0000, 32'h4433_2211);
      bus(1, 2'h0, 32'h2000_0001, 32'h0000_AA00);
      bus(1, 2'h1, 32'h2000_0002, 32'hBBBB_0000);
      bus(0, 2'h2, 32'h2000_0000, 32'h0);
      chk(q, 32'hBBBB_AA11);
      bus(1, 2'h2, 32'h2000_00FC, 32'h5A5A_0FF0);
      bus(0, 2'h0, 32'h2000_00FC, 32'h0);
      chk(q, 32'h5A5A_0FF0);
      bus(0, 2'h2, 32'h2000_0100, 32'h0);
      chk({31'h0, e}, 32'h0000_0001);
      $display("test sram done");
   endtask
   // Alias writes and reads over SRAM
   task automatic t_alias;
      bus(1, 2'h2, 32'h2000_0010, 32'h0);
      bus(1, 2'h2, 32'h2200_0208, 32'hFFFF_FFFE);
      bus(0, 2'h2, 32'h2000_0010, 32'h0);
      chk(q, 32'h0000_0000);
      bus(1, 2'h2, 32'h2200_0208, 32'h0000_0001);
      bus(1, 2'h2, 32'h2200_027C, 32'h0000_0001);
      bus(0, 2'h2, 32'h2000_0010, 32'h0);
      chk(q, 32'h8000_0004);
      bus(0, 2'h2, 32'h2200_0208, 32'h0);
      chk(q, 32'h0000_0001);
      bus(0, 2'h2, 32'h2200_020C, 32'h0);
      chk(q, 32'h0000_0000);
      bus(1, 2'h2, 32'h2200_0208, 32'h0000_0000);
      bus(0, 2'h2, 32'h2000_0010, 32'h0);
      chk(q, 32'h8000_0000);
      $display("test alias done");
   endtask
   // Every window routes to its own store, gaps refused
   task automatic t_map;
      logic [31:0] b [0:14];
      b = '{32'h4002_0000, 32'h4002_0400, 32'h4002_1000, 32'h4002_2000, 32'h4002_3000,
         32'h4001_0800, 32'h4001_0C00, 32'h4001_1000, 32'h4001_1400, 32'h4001_1800,
         32'h4001_1C00, 32'h4001_2000, 32'h4000_3C00, 32'h4000_4C00, 32'h4000_5000};
      for (i = 0; i < 15; i++) bus(1, 2'h2, b[i], 32'hC0DE_0000 + i);
      for (i = 0; i < 15; i++) begin
         bus(0, 2'h2, b[i], 32'h0);
         chk(q, 32'hC0DE_0000 + i);
      end
      bus(0, 2'h2, 32'h4002_0800, 32'h0);
      chk({31'h0, e}, 32'h0000_0001);
      bus(1, 2'h2, 32'h4002_1400, 32'h0);
      chk({31'h0, e}, 32'h0000_0001);
      bus(0, 2'h2, 32'h4002_2400, 32'h0);
      chk({31'h0, e}, 32'h0000_0001);
      $display("test map done");
   endtask
   // Alias access into a port register
   task automatic t_per_alias;
      bus(1, 2'h2, 32'h4001_0804, 32'h0);
      bus(1, 2'h2, 32'h4221_00AC, 32'h0000_0001);
      bus(0, 2'h2, 32'h4001_0804, 32'h0);
      chk(q, 32'h0000_0800);
      bus(0, 2'h2, 32'h4221_00AC, 32'h0);
      chk(q, 32'h0000_0001);
      $display("test peripheral alias done");
   endtask
   // Verdict and end of run
   task automatic results;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Clock at 50 MHz
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Hang guard
   initial begin
      #200000;
      bad_count++;
      results;
   end
   // Main sequence
   initial begin
      {sys_rst, req, we, size, addr, wdata} = {1'b1, 1'b0, 1'b0, 2'h0, 32'h0, 32'h0};
      repeat (20) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      t_sram;
      t_alias;
      t_map;
      t_per_alias;
      results;
   end
endmodule
bind bbad_top bbad_monitor mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .we(we),
   .addr(addr), .ack_r(ack_r), .err_r(err_r), .rdata_r(rdata_r), .per_stb_r(per_stb_r),
   .per_addr_r(per_addr_r), .per_sel_r(per_sel_r));
`default_nettype wire
